/* src/mps_power_ctrl.sv */
/*
 Power-state controller of a cellular modem module: OFF, ON, sleep and
 deep-sleep states, power toggle and wake pin, fast and unconditional
 shutdown, power-on indicator. Assumes host commands arrive as one-cycle
 pulses from logic on clk_sys and that pins are asynchronous.
*/
// Functional notes
// - OFF keeps only the clock; exit goes to BOOT
// - ON powers baseband and accepts commands
// - Sleep gates processor, commands still served
// - Deep sleep keeps baseband mostly off
// - Pin held low loses asynchronous wake
// - Halt line resets outside deep sleep and OFF, then off without detach
// - Timer expiry with saving mode enters deep sleep
// - Wake needs low pin for five seconds
// - Normal shutdown detaches and closes files
// - Falling trigger pin starts fast shutdown
// - Fast shutdown command starts fast shutdown
// - Fast shutdown is short and low current
// - Indicator high whenever powered on
// - Indicator low during saving mode period
`timescale 1ns/1ps
`default_nettype none
`include "mps_cfg.svh"
module mps_power_ctrl #(
   parameter int CNT_W = `MPS_CNT_W,
   parameter logic [CNT_W-1:0] WAKE_CYC = CNT_W'(`MPS_WAKE_MIN_CYC),
   parameter logic [CNT_W-1:0] TOGGLE_CYC = CNT_W'(`MPS_TOGGLE_MIN_CYC),
   parameter logic [CNT_W-1:0] NORM_CYC = CNT_W'(`MPS_NORM_SHDN_CYC),
   parameter logic [CNT_W-1:0] FAST_CYC = CNT_W'(`MPS_FAST_SHDN_CYC),
   parameter logic [CNT_W-1:0] BOOT_CYC = CNT_W'(`MPS_BOOT_CYC)
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic on_off_wake_n,
   input wire logic fast_trig_pin,
   input wire logic fast_trig_en,
   input wire logic psm_enabled,
   input wire logic update_timer_expired,
   input wire logic sleep_allowed,
   input wire logic cmd_activity,
   input wire logic shutdown_command,
   input wire logic system_halt_command,
   input wire logic fast_shutdown_command,
   input wire logic unconditional_shutdown_n,
   output logic power_on_indicator,
   output logic baseband_power,
   output logic cpu_power,
   output logic cmd_ready,
   output logic network_detach,
   output logic fs_close,
   output logic fast_mode,
   output logic [2:0] power_state
);
   typedef struct packed {
      mps_pkg::mps_state_t st;
      logic [CNT_W-1:0] cnt;
      logic duty;
      logic ft1;
      logic ft2;
      logic ft_prev;
      logic us1;
      logic us2;
      logic halted;
      logic armed;
      logic ind;
      logic bb;
      logic cpu;
      logic rdy;
      logic det;
      logic fsc;
      logic fm;
   } mps_st_t;
   mps_st_t s_reg;
   mps_st_t s_next;

   logic wake_held;
   logic wake_fall;
   logic wake_low;
   logic [CNT_W-1:0] wake_limit;
   logic ft_fall;

   // Wake pulse qualified only after the full low time
   assign wake_limit = (s_reg.st == mps_pkg::MPS_PSM) ? WAKE_CYC
                                                      : TOGGLE_CYC;

   mps_low_timer #(.CNT_W(CNT_W)) u_wake (
      .clk_sys(clk_sys),
      .rst(rst),
      .pin_n(on_off_wake_n),
      .limit(wake_limit),
      .held(wake_held),
      .fall(wake_fall),
      .level_low(wake_low)
   );

   assign ft_fall = fast_trig_en & s_reg.ft_prev & ~s_reg.ft2;

   always_comb begin
      s_next = s_reg;
      s_next.ft1 = fast_trig_pin;
      s_next.ft2 = s_reg.ft1;
      s_next.ft_prev = s_reg.ft2;
      s_next.us1 = unconditional_shutdown_n;
      s_next.us2 = s_reg.us1;
      s_next.cnt = s_reg.cnt + 1'b1;
      if (s_reg.st != mps_pkg::MPS_PSM && !s_reg.us2 &&
          s_reg.st != mps_pkg::MPS_OFF) begin
         // Held reset: stop all, power off without detach
         s_next.st = mps_pkg::MPS_HALT;
         s_next.cnt = '0;
      end else begin
         unique case (s_reg.st)
            mps_pkg::MPS_OFF: begin
               s_next.cnt = '0;
               if (wake_held) begin
                  s_next.st = mps_pkg::MPS_BOOT;
               end
            end
            mps_pkg::MPS_BOOT: begin
               if (s_reg.cnt >= BOOT_CYC && wake_low == 1'b0) begin
                  s_next.st = mps_pkg::MPS_ON;
                  s_next.cnt = '0;
               end
            end
            mps_pkg::MPS_ON: begin
               s_next.cnt = '0;
               if (fast_shutdown_command || ft_fall) begin
                  s_next.st = mps_pkg::MPS_SHDN_FAST;
               end else if (shutdown_command || system_halt_command ||
                            (wake_held && !wake_fall)) begin
                  s_next.st = mps_pkg::MPS_SHDN_NORM;
               end else if (psm_enabled && update_timer_expired) begin
                  s_next.st = mps_pkg::MPS_PSM;
               end else if (sleep_allowed && !cmd_activity) begin
                  s_next.st = mps_pkg::MPS_SLEEP;
               end
            end
            mps_pkg::MPS_SLEEP: begin
               // Processor powered on alternate slices
               if (s_reg.cnt[7:0] == 8'hFF) begin
                  s_next.duty = ~s_reg.duty;
               end
               if (fast_shutdown_command || ft_fall) begin
                  s_next.st = mps_pkg::MPS_SHDN_FAST;
                  s_next.cnt = '0;
               end else if (shutdown_command || system_halt_command) begin
                  s_next.st = mps_pkg::MPS_SHDN_NORM;
                  s_next.cnt = '0;
               end else if (psm_enabled && update_timer_expired) begin
                  s_next.st = mps_pkg::MPS_PSM;
                  s_next.cnt = '0;
               end else if (cmd_activity || !sleep_allowed) begin
                  s_next.st = mps_pkg::MPS_ON;
                  s_next.duty = 1'b0;
               end
            end
            mps_pkg::MPS_PSM: begin
               s_next.cnt = '0;
               // A pin tied low never falls here, so it cannot wake
               s_next.armed = s_reg.armed | wake_fall;
               if (wake_held && s_reg.armed) begin
                  s_next.st = mps_pkg::MPS_BOOT;
               end
            end
            mps_pkg::MPS_SHDN_NORM: begin
               if (s_reg.cnt >= NORM_CYC) begin
                  s_next.st = mps_pkg::MPS_OFF;
               end else if (fast_shutdown_command || ft_fall) begin
                  s_next.st = mps_pkg::MPS_SHDN_FAST;
                  s_next.cnt = '0;
               end
            end
            mps_pkg::MPS_SHDN_FAST: begin
               if (s_reg.cnt >= FAST_CYC) begin
                  s_next.st = mps_pkg::MPS_OFF;
               end
            end
            mps_pkg::MPS_HALT: begin
               s_next.cnt = '0;
               if (s_reg.us2) begin
                  s_next.st = mps_pkg::MPS_OFF;
               end
            end
         endcase
      end
      s_next.halted = (s_next.st == mps_pkg::MPS_HALT);
      // Outputs registered from the next state
      s_next.ind = (s_next.st != mps_pkg::MPS_OFF) &&
                   (s_next.st != mps_pkg::MPS_PSM) &&
                   !s_next.halted;
      s_next.bb = s_next.ind;
      s_next.cpu = s_next.ind &&
                   !(s_next.st == mps_pkg::MPS_SLEEP && s_next.duty);
      s_next.rdy = (s_next.st == mps_pkg::MPS_ON) ||
                   (s_next.st == mps_pkg::MPS_SLEEP);
      s_next.det = (s_next.st == mps_pkg::MPS_SHDN_NORM);
      s_next.fsc = (s_next.st == mps_pkg::MPS_SHDN_NORM) ||
                   (s_next.st == mps_pkg::MPS_SHDN_FAST);
      s_next.fm = (s_next.st == mps_pkg::MPS_SHDN_FAST);
      if (s_next.st != mps_pkg::MPS_SLEEP) begin
         s_next.duty = 1'b0;
      end
      if (s_next.st != mps_pkg::MPS_PSM) begin
         s_next.armed = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_reg <= '{st: mps_pkg::MPS_OFF, cnt: '0, duty: 1'b0,
                    ft1: 1'b1, ft2: 1'b1, ft_prev: 1'b1, us1: 1'b1,
                    us2: 1'b1, halted: 1'b0, armed: 1'b0, ind: 1'b0, bb: 1'b0,
                    cpu: 1'b0, rdy: 1'b0, det: 1'b0, fsc: 1'b0,
                    fm: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign power_on_indicator = s_reg.ind;
   assign baseband_power = s_reg.bb;
   assign cpu_power = s_reg.cpu;
   assign cmd_ready = s_reg.rdy;
   assign network_detach = s_reg.det;
   assign fs_close = s_reg.fsc;
   assign fast_mode = s_reg.fm;
   assign power_state = s_reg.st;

   property p_psm_ind_low;
      @(posedge clk_sys) disable iff (rst)
         (s_reg.st == mps_pkg::MPS_PSM) |-> !power_on_indicator;
   endproperty
   a_psm_ind_low: assert property (p_psm_ind_low)
      else $error("indicator high in deep sleep");

   property p_on_ind_high;
      @(posedge clk_sys) disable iff (rst)
         (s_reg.st == mps_pkg::MPS_ON) |-> power_on_indicator && cmd_ready;
   endproperty
   a_on_ind_high: assert property (p_on_ind_high)
      else $error("indicator or ready low while on");

   property p_off_exit;
      @(posedge clk_sys) disable iff (rst)
         (s_reg.st == mps_pkg::MPS_OFF) |=>
            (s_reg.st == mps_pkg::MPS_OFF || s_reg.st == mps_pkg::MPS_BOOT);
   endproperty
   a_off_exit: assert property (p_off_exit)
      else $error("left off state to a wrong state");

   property p_psm_bb_off;
      @(posedge clk_sys) disable iff (rst)
         (s_reg.st == mps_pkg::MPS_PSM) |-> !baseband_power;
   endproperty
   a_psm_bb_off: assert property (p_psm_bb_off)
      else $error("baseband on in deep sleep");

   property p_psm_enter;
      @(posedge clk_sys) disable iff (rst)
         (s_reg.st == mps_pkg::MPS_ON && psm_enabled && update_timer_expired
          && s_reg.us2 && !fast_shutdown_command && !ft_fall
          && !shutdown_command && !system_halt_command && !wake_held)
         |=> (s_reg.st == mps_pkg::MPS_PSM);
   endproperty
   a_psm_enter: assert property (p_psm_enter)
      else $error("timer expiry did not enter deep sleep");

   property p_wake_only_held;
      @(posedge clk_sys) disable iff (rst)
         (s_reg.st == mps_pkg::MPS_PSM && !wake_held) |=>
            (s_reg.st == mps_pkg::MPS_PSM);
   endproperty
   a_wake_only_held: assert property (p_wake_only_held)
      else $error("woke without a full wake pulse");

   property p_fast_cmd;
      @(posedge clk_sys) disable iff (rst)
         (s_reg.st == mps_pkg::MPS_ON && fast_shutdown_command && s_reg.us2)
         |=> (s_reg.st == mps_pkg::MPS_SHDN_FAST) ##1 fast_mode;
   endproperty
   a_fast_cmd: assert property (p_fast_cmd)
      else $error("fast shutdown command ignored");

   property p_fast_pin;
      @(posedge clk_sys) disable iff (rst)
         (s_reg.st == mps_pkg::MPS_ON && ft_fall && s_reg.us2) |=>
            (s_reg.st == mps_pkg::MPS_SHDN_FAST);
   endproperty
   a_fast_pin: assert property (p_fast_pin)
      else $error("trigger pin fall ignored");

   property p_halt;
      @(posedge clk_sys) disable iff (rst)
         (s_reg.st == mps_pkg::MPS_ON && !s_reg.us2) |=>
            (s_reg.st == mps_pkg::MPS_HALT) ##1 !baseband_power;
   endproperty
   a_halt: assert property (p_halt)
      else $error("unconditional shutdown not taken");

   property p_sleep_ready;
      @(posedge clk_sys) disable iff (rst)
         (s_reg.st == mps_pkg::MPS_SLEEP) |-> cmd_ready;
   endproperty
   a_sleep_ready: assert property (p_sleep_ready)
      else $error("commands refused in sleep");
endmodule : mps_power_ctrl
`default_nettype wire

/* src/mps_cfg.svh */
/*
 Constants for the module power-state controller: timing figures and
 derived cycle counts. Assumes a 100 MHz system clock.
*/
`ifndef MPS_CFG_SVH
`define MPS_CFG_SVH
`define MPS_CLK_HZ 100000000
`define MPS_WAKE_MIN_S 5
`define MPS_WAKE_MIN_CYC (`MPS_WAKE_MIN_S * `MPS_CLK_HZ)
`define MPS_TOGGLE_MIN_MS 1000
`define MPS_TOGGLE_MIN_CYC (`MPS_TOGGLE_MIN_MS * (`MPS_CLK_HZ / 1000))
`define MPS_NORM_SHDN_CYC 200000000
`define MPS_FAST_SHDN_CYC 1000000
`define MPS_BOOT_CYC 100000
`define MPS_CNT_W 32
`endif

/* src/mps_pkg.sv */
/*
 Types for the module power-state controller.
 Assumes the constants header is included by the design files.
*/
package mps_pkg;
   typedef enum logic [2:0] {
      MPS_OFF,
      MPS_BOOT,
      MPS_ON,
      MPS_SLEEP,
      MPS_PSM,
      MPS_SHDN_NORM,
      MPS_SHDN_FAST,
      MPS_HALT
   } mps_state_t;
endpackage : mps_pkg

/* src/mps_low_timer.sv */
/*
 Synchronises an active-low pin and reports when it has stayed low for a
 programmable count of cycles. Assumes the pin is asynchronous to clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module mps_low_timer #(
   parameter int CNT_W = 32
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic pin_n,
   input wire logic [CNT_W-1:0] limit,
   output logic held,
   output logic fall,
   output logic level_low
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic prev;
      logic [CNT_W-1:0] cnt;
      logic held;
      logic fall;
   } mps_lt_t;
   mps_lt_t st_reg;
   mps_lt_t st_next;

   always_comb begin
      st_next = st_reg;
      st_next.s1 = pin_n;
      st_next.s2 = st_reg.s1;
      st_next.prev = st_reg.s2;
      st_next.fall = st_reg.prev & ~st_reg.s2;
      // Count only an unbroken low level
      if (st_reg.s2) begin
         st_next.cnt = '0;
         st_next.held = 1'b0;
      end else if (st_reg.cnt >= limit) begin
         st_next.held = 1'b1;
      end else begin
         st_next.cnt = st_reg.cnt + 1'b1;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_reg <= '{s1: 1'b1, s2: 1'b1, prev: 1'b1, cnt: '0,
                     held: 1'b0, fall: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign held = st_reg.held;
   assign fall = st_reg.fall;
   assign level_low = ~st_reg.prev;
endmodule : mps_low_timer
`default_nettype wire

/* bench/mps_host_model.sv */
/*
 Host controller model: drives the power toggle pin, the fast trigger pin
 and the command pulses. Assumes it shares clk_sys with the controller.
*/
`timescale 1ns/1ps
`default_nettype none
module mps_host_model (
   input wire logic clk_sys,
   output logic on_off_wake_n,
   output logic fast_trig_pin,
   output logic shutdown_command,
   output logic system_halt_command,
   output logic fast_shutdown_command
);
   // Supply is never cut by this host
   initial begin
      on_off_wake_n = 1'b1;
      fast_trig_pin = 1'b1;
      shutdown_command = 1'b0;
      system_halt_command = 1'b0;
      fast_shutdown_command = 1'b0;
   end
   // Level of the toggle and wake pin
   task automatic set_pin(input logic v);
      @(posedge clk_sys);
      on_off_wake_n <= v;
   endtask : set_pin
   task automatic set_trig(input logic v);
      @(posedge clk_sys);
      fast_trig_pin <= v;
   endtask : set_trig
   // One-cycle command pulse: 0 shutdown, 1 halt, 2 fast
   task automatic cmd(input int k);
      @(posedge clk_sys);
      shutdown_command <= (k == 0);
      system_halt_command <= (k == 1);
      fast_shutdown_command <= (k == 2);
      @(posedge clk_sys);
      shutdown_command <= 1'b0;
      system_halt_command <= 1'b0;
      fast_shutdown_command <= 1'b0;
   endtask : cmd
endmodule : mps_host_model
`default_nettype wire

/* bench/tb_top.sv */
/*
 Self-checking bench of the power-state controller with shortened counts.
 Assumes the host model drives pins and commands on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic fast_trig_en = 1'b0;
   logic psm_enabled = 1'b0;
   logic update_timer_expired = 1'b0;
   logic sleep_allowed = 1'b0;
   logic cmd_activity = 1'b0;
   logic unconditional_shutdown_n = 1'b1;
   logic on_off_wake_n, fast_trig_pin, shutdown_command;
   logic system_halt_command, fast_shutdown_command;
   logic power_on_indicator, baseband_power, cpu_power, cmd_ready;
   logic network_detach, fs_close, fast_mode;
   logic [2:0] power_state;
   int n_fail = 0;
   int comparisons = 0;
   int cyc = 0;
   int n;
   always #5 clk_sys = ~clk_sys;
   mps_host_model host (.clk_sys(clk_sys), .on_off_wake_n(on_off_wake_n),
      .fast_trig_pin(fast_trig_pin), .shutdown_command(shutdown_command),
      .system_halt_command(system_halt_command),
      .fast_shutdown_command(fast_shutdown_command));
   mps_power_ctrl #(.WAKE_CYC(32'h32), .TOGGLE_CYC(32'h14),
      .NORM_CYC(32'h64), .FAST_CYC(32'h0A), .BOOT_CYC(32'h05)) dut (
      .clk_sys(clk_sys), .rst(rst), .on_off_wake_n(on_off_wake_n),
      .fast_trig_pin(fast_trig_pin), .fast_trig_en(fast_trig_en),
      .psm_enabled(psm_enabled),
      .update_timer_expired(update_timer_expired),
      .sleep_allowed(sleep_allowed), .cmd_activity(cmd_activity),
      .shutdown_command(shutdown_command),
      .system_halt_command(system_halt_command),
      .fast_shutdown_command(fast_shutdown_command),
      .unconditional_shutdown_n(unconditional_shutdown_n),
      .power_on_indicator(power_on_indicator),
      .baseband_power(baseband_power), .cpu_power(cpu_power),
      .cmd_ready(cmd_ready), .network_detach(network_detach),
      .fs_close(fs_close), .fast_mode(fast_mode),
      .power_state(power_state));
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : close_out
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_fail++;
         close_out();
      end
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Wait for a state under a bound, then compare it
   task automatic wait_st(input logic [2:0] st, input int lim);
      n = 0;
      while (power_state !== st && n < lim) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      chk(8'(power_state), 8'(st));
   endtask : wait_st
   task automatic power_up();
      host.set_pin(1'b0);
      wait_st(mps_pkg::MPS_BOOT, 60);
      chk(8'(power_on_indicator), 8'h01);
      host.set_pin(1'b1);
      wait_st(mps_pkg::MPS_ON, 30);
      chk(8'({cmd_ready, baseband_power, cpu_power}), 8'h07);
   endtask : power_up
   task automatic t_refused();
      host.cmd(0);
      host.cmd(2);
      repeat (5) @(posedge clk_sys);
      #1;
      chk(8'(power_state), 8'(mps_pkg::MPS_OFF));
      $display("test refused done");
   endtask : t_refused
   task automatic t_sleep_fast();
      power_up();
      @(posedge clk_sys);
      sleep_allowed <= 1'b1;
      wait_st(mps_pkg::MPS_SLEEP, 20);
      chk(8'({cmd_ready, power_on_indicator}), 8'h03);
      @(posedge clk_sys);
      cmd_activity <= 1'b1;
      wait_st(mps_pkg::MPS_ON, 4);
      @(posedge clk_sys);
      cmd_activity <= 1'b0;
      wait_st(mps_pkg::MPS_SLEEP, 4);
      repeat (300) @(posedge clk_sys);
      #1;
      chk(8'({power_state == mps_pkg::MPS_SLEEP, cpu_power}), 8'h02);
      host.cmd(2);
      wait_st(mps_pkg::MPS_SHDN_FAST, 3);
      chk(8'({fast_mode, fs_close, network_detach}), 8'h06);
      wait_st(mps_pkg::MPS_OFF, 30);
      chk(8'(n <= 15), 8'h01);
      @(posedge clk_sys);
      sleep_allowed <= 1'b0;
      $display("test sleep fast done");
   endtask : t_sleep_fast
   task automatic t_normal(input int k);
      power_up();
      if (k < 2) begin
         host.cmd(k);
      end else begin
         host.set_pin(1'b0);
      end
      wait_st(mps_pkg::MPS_SHDN_NORM, 40);
      chk(8'({network_detach, fs_close, fast_mode}), 8'h06);
      host.set_pin(1'b1);
      wait_st(mps_pkg::MPS_OFF, 200);
      chk(8'(n >= 95), 8'h01);
      $display("test normal %0d done", k);
   endtask : t_normal
   task automatic t_fast_pin();
      power_up();
      host.set_trig(1'b0);
      repeat (10) @(posedge clk_sys);
      #1;
      chk(8'(power_state), 8'(mps_pkg::MPS_ON));
      host.set_trig(1'b1);
      repeat (5) @(posedge clk_sys);
      fast_trig_en <= 1'b1;
      host.set_trig(1'b0);
      wait_st(mps_pkg::MPS_SHDN_FAST, 6);
      host.set_trig(1'b1);
      wait_st(mps_pkg::MPS_OFF, 30);
      @(posedge clk_sys);
      fast_trig_en <= 1'b0;
      power_up();
      host.cmd(2);
      wait_st(mps_pkg::MPS_SHDN_FAST, 3);
      chk(8'({fast_mode, network_detach}), 8'h02);
      wait_st(mps_pkg::MPS_OFF, 30);
      $display("test fast pin done");
   endtask : t_fast_pin
   task automatic t_uncond();
      power_up();
      @(posedge clk_sys);
      unconditional_shutdown_n <= 1'b0;
      wait_st(mps_pkg::MPS_HALT, 6);
      chk(8'({power_on_indicator, network_detach}), 8'h00);
      @(posedge clk_sys);
      unconditional_shutdown_n <= 1'b1;
      wait_st(mps_pkg::MPS_OFF, 10);
      $display("test unconditional done");
   endtask : t_uncond
   task automatic t_psm();
      power_up();
      host.set_pin(1'b0);
      repeat (8) @(posedge clk_sys);
      psm_enabled <= 1'b1;
      update_timer_expired <= 1'b1;
      @(posedge clk_sys);
      update_timer_expired <= 1'b0;
      wait_st(mps_pkg::MPS_PSM, 6);
      chk(8'({power_on_indicator, baseband_power}), 8'h00);
      @(posedge clk_sys);
      unconditional_shutdown_n <= 1'b0;
      repeat (10) @(posedge clk_sys);
      unconditional_shutdown_n <= 1'b1;
      repeat (40) @(posedge clk_sys);
      #1;
      chk(8'(power_state), 8'(mps_pkg::MPS_PSM));
      host.set_pin(1'b1);
      repeat (8) @(posedge clk_sys);
      host.set_pin(1'b0);
      repeat (30) @(posedge clk_sys);
      host.set_pin(1'b1);
      repeat (8) @(posedge clk_sys);
      #1;
      chk(8'(power_state), 8'(mps_pkg::MPS_PSM));
      host.set_pin(1'b0);
      wait_st(mps_pkg::MPS_BOOT, 80);
      chk(8'(n >= 48), 8'h01);
      host.set_pin(1'b1);
      wait_st(mps_pkg::MPS_ON, 30);
      @(posedge clk_sys);
      psm_enabled <= 1'b0;
      $display("test psm done");
   endtask : t_psm
   initial begin
      repeat (3) @(posedge clk_sys);
      #1;
      chk(8'({power_state, power_on_indicator, cmd_ready}), 8'h00);
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      t_refused();
      t_sleep_fast();
      t_normal(0);
      t_normal(1);
      t_normal(2);
      t_fast_pin();
      t_uncond();
      t_psm();
      close_out();
   end
endmodule : tb_top
`default_nettype wire
